/* src/csc_top.sv */
// System control pin logic with Avalon-MM register access
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module csc_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic addr_strobe,
	input wire logic core_lock_req,
	input wire logic core_lock_last,
	input wire logic cycle_ready_in,
	output logic bus_lock_out,
	input wire logic boot_width_strap_a,
	input wire logic boot_width_strap_b,
	output logic [1:0] cs0_width_out,
	input wire logic sync_trap_in,
	input wire logic [7:0] trap_type_in,
	input wire logic [31:0] core_pc_in,
	input wire logic [31:0] core_npc_in,
	output logic halted_error_n_out,
	input wire logic [3:0] irq_level_in,
	output logic nmi_req_out,
	output logic irq_req_out,
	output logic [3:0] irq_taken_level_out,
	input wire logic dma_count_zero_in,
	input wire logic dma_to_sdram_in,
	input wire logic sdram_busy_in,
	output logic transfer_done_n_out,
	input wire logic debug_enable_strap_n,
	input wire logic debug_break_n_in,
	input wire logic core_debug_fetch,
	output logic debug_trap_out,
	output logic [31:0] start_vector_out,
	output logic debug_state_out,
	input wire logic core_sleep_done_in,
	input wire logic wake_n_in,
	input wire logic clock_stop_n_in,
	output logic sleep_entered_n_out,
	output logic resume_out,
	output logic pll_stop_out
);
	logic [31:0] ctrl_reg;
	logic [31:0] trap_base_reg;
	logic [31:0] saved_pc_reg;
	logic [31:0] saved_npc_reg;
	logic error_reg;
	logic dma_pend_reg;
	csc_pkg::csc_pwr_type pwr_reg;
	csc_pkg::csc_pwr_type pwr_next;
	logic [1:0] strap_width;
	logic strap_debug_en;
	logic strap_debug_boot;
	logic strap_valid;
	logic wake_sync_n;

	csc_strap u_strap (
		.mclk(mclk),
		.nrst(nrst),
		.boot_width_strap_a(boot_width_strap_a),
		.boot_width_strap_b(boot_width_strap_b),
		.debug_enable_strap_n(debug_enable_strap_n),
		.debug_break_n_in(debug_break_n_in),
		.width_out(strap_width),
		.debug_en_out(strap_debug_en),
		.debug_boot_out(strap_debug_boot),
		.valid_out(strap_valid)
	);

	csc_sync2 u_wake_sync (
		.mclk(mclk),
		.nrst(nrst),
		.async_in(wake_n_in),
		.sync_out(wake_sync_n)
	);

	// Bus decode; an access completes at the edge where waitrequest is low
	wire bus_req = avs_read || avs_write;
	wire bus_done = bus_req && !avs_waitrequest;
	wire wr_ctrl = avs_write && bus_done && (avs_address == csc_pkg::ADDR_CTRL);
	wire wr_tbr = avs_write && bus_done &&
		(avs_address == csc_pkg::ADDR_TRAP_BASE);
	wire trap_en = ctrl_reg[csc_pkg::CTRL_TRAP_EN_BIT];
	wire sleep_req = ctrl_reg[csc_pkg::CTRL_SLEEP_REQ_BIT];
	wire [3:0] proc_irq_level_field = ctrl_reg[csc_pkg::CTRL_PIL_LSB +: 4];
	wire error_hit = sync_trap_in && !trap_en && !error_reg;
	wire [31:0] status_word = {24'h0, strap_width, pwr_reg, 1'b0,
		debug_state_out, strap_debug_en, error_reg};
	wire [31:0] rd_mux =
		(avs_address == csc_pkg::ADDR_CTRL) ? ctrl_reg :
		(avs_address == csc_pkg::ADDR_STATUS) ? status_word :
		(avs_address == csc_pkg::ADDR_TRAP_BASE) ? trap_base_reg :
		(avs_address == csc_pkg::ADDR_SAVED_PC) ? saved_pc_reg :
		(avs_address == csc_pkg::ADDR_SAVED_NPC) ? saved_npc_reg : 32'h0;
	wire wake_now = !wake_sync_n;
	wire asleep = (pwr_reg == csc_pkg::CSC_SLEEP) ||
		(pwr_reg == csc_pkg::CSC_STOP);
	wire resume_hit = asleep && wake_now;
	// Hardware clears the sleep request on wake; a software write wins
	wire [31:0] ctrl_next_wr = avs_writedata;
	wire [31:0] ctrl_hw = resume_hit ?
		(ctrl_reg & ~(32'h1 << csc_pkg::CTRL_SLEEP_REQ_BIT)) : ctrl_reg;
	wire dma_fire = (dma_pend_reg || dma_count_zero_in) &&
		(dma_to_sdram_in || !sdram_busy_in);

	// Wait one cycle per access, then release for exactly one edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
			avs_readdata <= (avs_read && avs_waitrequest) ? rd_mux : 32'h0;
		end
	end

	// Control register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= csc_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= wr_ctrl ? ctrl_next_wr : ctrl_hw;
		end
	end

	// Error capture: trap with traps off saves state and halts until reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			error_reg <= 1'b0;
			trap_base_reg <= csc_pkg::TRAP_BASE_RESET;
			saved_pc_reg <= 32'h0;
			saved_npc_reg <= 32'h0;
			halted_error_n_out <= 1'b1;
		end else begin
			if (error_hit) begin
				error_reg <= 1'b1;
				saved_pc_reg <= core_pc_in;
				saved_npc_reg <= core_npc_in;
				trap_base_reg[csc_pkg::TT_LSB +: 8] <= trap_type_in;
			end else if (wr_tbr) begin
				trap_base_reg <= avs_writedata;
			end
			halted_error_n_out <= !(error_reg || error_hit);
		end
	end

	// Bus lock spans the locked transaction
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_lock_out <= 1'b0;
		end else if (addr_strobe && core_lock_req) begin
			bus_lock_out <= 1'b1;
		end else if (cycle_ready_in && core_lock_last) begin
			bus_lock_out <= 1'b0;
		end
	end

	// Interrupt level decode, pins taken as synchronous
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nmi_req_out <= 1'b0;
			irq_req_out <= 1'b0;
			irq_taken_level_out <= 4'h0;
		end else begin
			nmi_req_out <= irq_level_in == csc_pkg::IRQ_NMI;
			irq_req_out <= csc_pkg::csc_irq_take(irq_level_in, proc_irq_level_field);
			irq_taken_level_out <= irq_level_in;
		end
	end

	// Done waits for SDRAM only when SDRAM is the source
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dma_pend_reg <= 1'b0;
			transfer_done_n_out <= 1'b1;
		end else begin
			dma_pend_reg <= (dma_pend_reg || dma_count_zero_in) && !dma_fire;
			transfer_done_n_out <= !dma_fire;
		end
	end

	// Debug outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			debug_trap_out <= 1'b0;
			debug_state_out <= 1'b0;
			start_vector_out <= csc_pkg::BOOT_VECTOR;
		end else begin
			debug_trap_out <= strap_valid && strap_debug_en &&
				!debug_break_n_in;
			if (addr_strobe) begin
				debug_state_out <= core_debug_fetch;
			end
			start_vector_out <= (strap_valid && strap_debug_boot) ?
				csc_pkg::DEBUG_VECTOR : csc_pkg::BOOT_VECTOR;
		end
	end

	// Power state machine
	always_comb begin
		pwr_next = pwr_reg;
		unique case (pwr_reg)
			csc_pkg::CSC_RUN: begin
				if (sleep_req) begin
					pwr_next = csc_pkg::CSC_ENTER;
				end
			end
			csc_pkg::CSC_ENTER: begin
				if (core_sleep_done_in) begin
					pwr_next = csc_pkg::CSC_SLEEP;
				end
			end
			csc_pkg::CSC_SLEEP: begin
				if (wake_now) begin
					pwr_next = csc_pkg::CSC_RUN;
				end else if (!clock_stop_n_in) begin
					pwr_next = csc_pkg::CSC_STOP;
				end
			end
			csc_pkg::CSC_STOP: begin
				if (wake_now) begin
					pwr_next = csc_pkg::CSC_RUN;
				end
			end
		endcase
	end

	// Power state and its outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pwr_reg <= csc_pkg::CSC_RUN;
			sleep_entered_n_out <= 1'b1;
			resume_out <= 1'b0;
			pll_stop_out <= 1'b0;
			cs0_width_out <= 2'h0;
		end else begin
			pwr_reg <= pwr_next;
			sleep_entered_n_out <= !((pwr_next == csc_pkg::CSC_SLEEP) ||
				(pwr_next == csc_pkg::CSC_STOP));
			resume_out <= resume_hit;
			pll_stop_out <= pwr_next == csc_pkg::CSC_STOP;
			cs0_width_out <= strap_width;
		end
	end

	default clocking dflt_cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence lock_start_s;
		addr_strobe && core_lock_req;
	endsequence
	sequence err_trap_s;
		sync_trap_in && !trap_en && !error_reg;
	endsequence

	lock_rises_a: assert property (
		lock_start_s |=> bus_lock_out)
		else $error("bus lock not raised");
	error_holds_a: assert property (
		err_trap_s |=> !halted_error_n_out [*8])
		else $error("error output dropped");
	err_sticky_a: assert property (
		!halted_error_n_out |=> !halted_error_n_out)
		else $error("error output released");
	trap_save_a: assert property (
		err_trap_s |=> saved_pc_reg == $past(core_pc_in) &&
		saved_npc_reg == $past(core_npc_in) &&
		trap_base_reg[csc_pkg::TT_LSB +: 8] == $past(trap_type_in))
		else $error("trap state not saved");
	nmi_level_a: assert property (
		irq_level_in == csc_pkg::IRQ_NMI |=>
		nmi_req_out && !irq_req_out)
		else $error("all ones not taken as nmi");
	irq_none_a: assert property (
		irq_level_in == csc_pkg::IRQ_NONE |=>
		!irq_req_out && !nmi_req_out)
		else $error("level zero gave a request");
	dma_wait_a: assert property (
		!transfer_done_n_out && !$past(dma_to_sdram_in) |->
		!$past(sdram_busy_in))
		else $error("done while sdram busy");
	dbg_trap_a: assert property (
		strap_valid && strap_debug_en && !debug_break_n_in |=>
		debug_trap_out)
		else $error("debug trap not taken");
	dbg_ignore_a: assert property (
		strap_valid && !strap_debug_en |=> !debug_trap_out)
		else $error("break not ignored");
	debug_vec_a: assert property (
		strap_valid && strap_debug_boot |=>
		start_vector_out == csc_pkg::DEBUG_VECTOR)
		else $error("debug vector not used");
	dbg_state_a: assert property (
		addr_strobe && core_debug_fetch |=> debug_state_out)
		else $error("debug state not raised");
	sleep_gate_a: assert property (
		$fell(sleep_entered_n_out) |->
		$past(pwr_reg) != csc_pkg::CSC_RUN)
		else $error("sleep flagged before entry");
	wake_resume_a: assert property (
		resume_hit |=> resume_out && sleep_entered_n_out)
		else $error("wake did not resume");
	stop_enter_a: assert property (
		pwr_reg == csc_pkg::CSC_SLEEP && wake_sync_n &&
		!clock_stop_n_in |=> pll_stop_out)
		else $error("stop mode not entered");
	strap_hold_a: assert property (
		strap_valid && $past(strap_valid) |=> $stable(cs0_width_out))
		else $error("boot width changed");
	bus_ack_a: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
endmodule : csc_top

/* src/csc_pkg.sv */
// Constants, types and helpers for the system control pin block
// Function
// - Raise bus lock with address strobe of a locked transaction, drop at its ready.
// - Latch two width straps at reset release; 00/01/10/11 give 8/16/32/64-bit.
// - Synchronous trap with traps off saves both PCs, writes trap type, halts, flags error.
// - Error output stays high, inactive, while reset is applied.
// - Interrupt level all ones is a non-maskable request.
// - Level zero means none; other levels taken only above the processor level.
// - Transfer done pulses when the DMA transfer count reaches zero.
// - Memory-to-bus transfers signal done only after all SDRAM accesses finish.
// - Bus-to-memory transfers may signal done while the last SDRAM write runs.
// - Debug mode is enabled when the enable strap is low at reset release.
// - With debug enabled, an active break input takes a debug trap any cycle.
// - With debug disabled at reset, the break input is ignored entirely.
// - Break and enable both low at reset start execution at the debug vector.
// - Debug state rises with the first debug fetch strobe, falls at a normal fetch.
// - Sleep indication goes low only after sleep entry has fully completed.
// - The wake input is asynchronous and resumes execution during sleep.
// - Clock stop during sleep enters stop mode, halting the PLL and clocks.
package csc_pkg;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_TRAP_BASE = 5'h08;
	localparam logic [4:0] ADDR_SAVED_PC = 5'h0c;
	localparam logic [4:0] ADDR_SAVED_NPC = 5'h10;
	// Control register fields
	localparam int CTRL_TRAP_EN_BIT = 0;
	localparam int CTRL_SLEEP_REQ_BIT = 1;
	localparam int CTRL_PIL_LSB = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Trap type sits in bits 11:4 of the trap base register
	localparam int TT_LSB = 4;
	localparam logic [31:0] TRAP_BASE_RESET = 32'h0000_0000;
	localparam logic [3:0] IRQ_NONE = 4'h0;
	localparam logic [3:0] IRQ_NMI = 4'hf;
	localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
	localparam logic [31:0] DEBUG_VECTOR = 32'h0000_0ff0;
	typedef enum logic [1:0] {
		CSC_W8 = 2'h0,
		CSC_W16 = 2'h1,
		CSC_W32 = 2'h2,
		CSC_W64 = 2'h3
	} csc_width_type;
	typedef enum logic [1:0] {
		CSC_RUN = 2'h0,
		CSC_ENTER = 2'h1,
		CSC_SLEEP = 2'h3,
		CSC_STOP = 2'h2
	} csc_pwr_type;
	// Decide whether a level is taken against the processor level
	function automatic logic csc_irq_take(input logic [3:0] lvl,
		input logic [3:0] proc_irq_level_field);
		csc_irq_take = (lvl != IRQ_NONE) && (lvl != IRQ_NMI) && (lvl > proc_irq_level_field);
	endfunction : csc_irq_take
endpackage : csc_pkg

/* src/csc_sync2.sv */
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module csc_sync2 (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : csc_sync2

/* src/csc_strap.sv */
// Latches boot straps once at the first edge after reset release
`timescale 1ns/100ps
module csc_strap (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic boot_width_strap_a,
	input wire logic boot_width_strap_b,
	input wire logic debug_enable_strap_n,
	input wire logic debug_break_n_in,
	output logic [1:0] width_out,
	output logic debug_en_out,
	output logic debug_boot_out,
	output logic valid_out
);
	// Capture once, then hold until the next reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			width_out <= 2'h0;
			debug_en_out <= 1'b0;
			debug_boot_out <= 1'b0;
			valid_out <= 1'b0;
		end else if (!valid_out) begin
			width_out <= {boot_width_strap_a, boot_width_strap_b};
			debug_en_out <= !debug_enable_strap_n;
			debug_boot_out <= !debug_enable_strap_n && !debug_break_n_in;
			valid_out <= 1'b1;
		end
	end
endmodule : csc_strap

/* tb/csc_sys_model.sv */
// Model of the outside interrupt prioritiser and wake source
`timescale 1ns/100ps
module csc_sys_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [3:0] irq_src,
	input wire logic irq_ack,
	input wire logic wake_req,
	output logic [3:0] irq_level_in,
	output logic wake_n_in
);
	logic [2:0] wake_cnt;
	// Latch the highest level and hold it until acknowledged
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			irq_level_in <= 4'h0;
		else if (irq_ack)
			irq_level_in <= 4'h0;
		else if (irq_src > irq_level_in)
			irq_level_in <= irq_src;
	end
	// Wake pulse lasts three clocks, above the two clock minimum
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			wake_cnt <= 3'h0;
		else if (wake_req)
			wake_cnt <= 3'h3;
		else if (wake_cnt != 3'h0)
			wake_cnt <= wake_cnt - 3'h1;
	end
	assign wake_n_in = (wake_cnt == 3'h0);
endmodule : csc_sys_model

/* tb/csc_top_test.sv */
// Self-checking bench for the system control pin block
`timescale 1ns/100ps
module csc_top_test;
	logic mclk = 1'h0, nrst = 1'h0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
	logic addr_strobe = 1'h0, core_lock_req = 1'h0;
	logic core_lock_last = 1'h0, cycle_ready_in = 1'h0;
	logic boot_width_strap_a = 1'h1, boot_width_strap_b = 1'h0;
	logic sync_trap_in = 1'h0, dma_count_zero_in = 1'h0;
	logic [7:0] trap_type_in = 8'h00;
	logic [31:0] core_pc_in = 32'h0, core_npc_in = 32'h0;
	logic dma_to_sdram_in = 1'h0, sdram_busy_in = 1'h0;
	logic debug_enable_strap_n = 1'h0, debug_break_n_in = 1'h0;
	logic core_debug_fetch = 1'h0, core_sleep_done_in = 1'h0;
	logic clock_stop_n_in = 1'h1, wake_n_in, wake_req = 1'h0;
	logic [3:0] irq_level_in, irq_taken_level_out, irq_src = 4'h0;
	logic irq_ack = 1'h0, seen_resume = 1'h0;
	logic bus_lock_out, halted_error_n_out, nmi_req_out, irq_req_out;
	logic [1:0] cs0_width_out;
	logic transfer_done_n_out, debug_trap_out, debug_state_out;
	logic [31:0] start_vector_out;
	logic sleep_entered_n_out, resume_out, pll_stop_out;
	int num_errors = 0, checks = 0;
	// Level, expected nmi and maskable request, with the level at 5
	logic [7:0] irq_rows [6] = '{8'h00, 8'hf2, 8'h30, 8'h50, 8'h61, 8'he1};
	csc_top i_dut (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .addr_strobe,
		.core_lock_req, .core_lock_last, .cycle_ready_in, .bus_lock_out,
		.boot_width_strap_a, .boot_width_strap_b, .cs0_width_out,
		.sync_trap_in, .trap_type_in, .core_pc_in, .core_npc_in,
		.halted_error_n_out, .irq_level_in, .nmi_req_out, .irq_req_out,
		.irq_taken_level_out, .dma_count_zero_in, .dma_to_sdram_in,
		.sdram_busy_in, .transfer_done_n_out, .debug_enable_strap_n,
		.debug_break_n_in, .core_debug_fetch, .debug_trap_out,
		.start_vector_out, .debug_state_out, .core_sleep_done_in,
		.wake_n_in, .clock_stop_n_in, .sleep_entered_n_out, .resume_out,
		.pll_stop_out);
	csc_sys_model i_model (.mclk, .nrst, .irq_src, .irq_ack, .wake_req,
		.irq_level_in, .wake_n_in);
	// Clock and a sticky flag for the one-cycle resume pulse
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (resume_out === 1'h1) seen_resume <= 1'h1;
	task test_done;
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One bus access, held until waitrequest is seen low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		if (avs_waitrequest !== 1'h0) begin
			num_errors++;
			test_done;
		end
		rdata = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge mclk);
	endtask : bus
	task tick(input int k);
		repeat (k) @(posedge mclk);
	endtask : tick
	// Raise the strobe with an attribute for one cycle
	task strobe(input logic lock, input logic fetch);
		addr_strobe <= 1'h1;
		core_lock_req <= lock;
		core_debug_fetch <= fetch;
		@(posedge mclk);
		addr_strobe <= 1'h0;
		core_lock_req <= 1'h0;
		core_debug_fetch <= 1'h0;
		@(posedge mclk);
	endtask : strobe
	initial begin
		int n;
		tick(16);
		chk(halted_error_n_out, 1'h1);
		nrst <= 1'h1;
		tick(3);
		chk(cs0_width_out, csc_pkg::CSC_W32);
		chk(start_vector_out, csc_pkg::DEBUG_VECTOR);
		chk(debug_trap_out, 1'h1);
		boot_width_strap_a <= 1'h0;
		debug_break_n_in <= 1'h1;
		tick(3);
		chk(cs0_width_out, csc_pkg::CSC_W32);
		chk(debug_trap_out, 1'h0);
		bus(1'h1, csc_pkg::ADDR_STATUS, 32'hffff_ffff);
		bus(1'h0, csc_pkg::ADDR_STATUS, 32'h0);
		chk(rdata & 32'hf7, 32'h82);
		bus(1'h1, csc_pkg::ADDR_CTRL, 32'h50);
		bus(1'h0, csc_pkg::ADDR_CTRL, 32'h0);
		chk(rdata, 32'h50);
		bus(1'h0, 5'h14, 32'h0);
		chk(rdata, 32'h0);
		foreach (irq_rows[i]) begin
			irq_ack <= 1'h1;
			@(posedge mclk);
			irq_ack <= 1'h0;
			irq_src <= irq_rows[i][7:4];
			tick(4);
			chk({nmi_req_out, irq_req_out}, irq_rows[i][1:0]);
			chk(irq_taken_level_out, irq_rows[i][7:4]);
		end
		// Locked transfer: a plain ready must not end it
		strobe(1'h1, 1'h0);
		chk(bus_lock_out, 1'h1);
		cycle_ready_in <= 1'h1;
		@(posedge mclk);
		cycle_ready_in <= 1'h0;
		tick(2);
		chk(bus_lock_out, 1'h1);
		cycle_ready_in <= 1'h1;
		core_lock_last <= 1'h1;
		@(posedge mclk);
		cycle_ready_in <= 1'h0;
		core_lock_last <= 1'h0;
		@(posedge mclk);
		chk(bus_lock_out, 1'h0);
		// Memory to bus: done waits for the SDRAM side to go idle
		sdram_busy_in <= 1'h1;
		dma_count_zero_in <= 1'h1;
		@(posedge mclk);
		dma_count_zero_in <= 1'h0;
		tick(3);
		chk(transfer_done_n_out, 1'h1);
		sdram_busy_in <= 1'h0;
		tick(2);
		chk(transfer_done_n_out, 1'h0);
		tick(1);
		chk(transfer_done_n_out, 1'h1);
		sdram_busy_in <= 1'h1;
		dma_to_sdram_in <= 1'h1;
		dma_count_zero_in <= 1'h1;
		@(posedge mclk);
		dma_count_zero_in <= 1'h0;
		@(posedge mclk);
		chk(transfer_done_n_out, 1'h0);
		sdram_busy_in <= 1'h0;
		strobe(1'h0, 1'h1);
		tick(3);
		chk(debug_state_out, 1'h1);
		strobe(1'h0, 1'h0);
		chk(debug_state_out, 1'h0);
		// Sleep entry, then wake through the synchroniser
		bus(1'h1, csc_pkg::ADDR_CTRL, 32'h52);
		tick(2);
		chk(sleep_entered_n_out, 1'h1);
		core_sleep_done_in <= 1'h1;
		tick(2);
		chk(sleep_entered_n_out, 1'h0);
		core_sleep_done_in <= 1'h0;
		wake_req <= 1'h1;
		@(posedge mclk);
		wake_req <= 1'h0;
		tick(2);
		chk(sleep_entered_n_out, 1'h0);
		n = 0;
		while (sleep_entered_n_out !== 1'h1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		if (sleep_entered_n_out !== 1'h1) begin
			num_errors++;
			test_done;
		end
		bus(1'h0, csc_pkg::ADDR_CTRL, 32'h0);
		chk(rdata, 32'h50);
		chk(seen_resume, 1'h1);
		// Trap with traps on must not halt; with traps off it must
		core_pc_in <= 32'h0000_1234;
		core_npc_in <= 32'h0000_1238;
		trap_type_in <= 8'ha5;
		bus(1'h1, csc_pkg::ADDR_TRAP_BASE, 32'h0000_1000);
		for (int t = 1; t >= 0; t--) begin
			bus(1'h1, csc_pkg::ADDR_CTRL, {31'h28, t[0]});
			sync_trap_in <= 1'h1;
			@(posedge mclk);
			sync_trap_in <= 1'h0;
			@(posedge mclk);
			chk(halted_error_n_out, t[0]);
		end
		tick(5);
		chk(halted_error_n_out, 1'h0);
		bus(1'h0, csc_pkg::ADDR_TRAP_BASE, 32'h0);
		chk(rdata, 32'h0000_1a50);
		bus(1'h0, csc_pkg::ADDR_SAVED_PC, 32'h0);
		chk(rdata, 32'h0000_1234);
		bus(1'h0, csc_pkg::ADDR_SAVED_NPC, 32'h0);
		chk(rdata, 32'h0000_1238);
		// Clock stop while asleep
		bus(1'h1, csc_pkg::ADDR_CTRL, 32'h52);
		core_sleep_done_in <= 1'h1;
		tick(3);
		clock_stop_n_in <= 1'h0;
		tick(2);
		chk(pll_stop_out, 1'h1);
		// Wake out of stop mode through the synchroniser
		wake_req <= 1'h1;
		@(posedge mclk);
		wake_req <= 1'h0;
		tick(5);
		chk(pll_stop_out, 1'h0);
		// Second reset with debug disabled and 16-bit straps
		nrst <= 1'h0;
		core_sleep_done_in <= 1'h0;
		clock_stop_n_in <= 1'h1;
		debug_enable_strap_n <= 1'h1;
		boot_width_strap_b <= 1'h1;
		tick(2);
		chk(halted_error_n_out, 1'h1);
		nrst <= 1'h1;
		tick(3);
		chk(cs0_width_out, csc_pkg::CSC_W16);
		chk(start_vector_out, csc_pkg::BOOT_VECTOR);
		debug_break_n_in <= 1'h0;
		tick(3);
		chk(debug_trap_out, 1'h0);
		test_done;
	end
endmodule : csc_top_test
